// ### phpr_port.sv
// Parallel handshake port: reset, lanes, handshake and AXI4-Lite registers.
`timescale 1ns/1ps
// Function
// R1: Reset pulses peripheral reset low 15 us.
// R2: Reset clears the request strobe.
// R3: Optional jumper clears data outputs.
// R4: Reset clears interrupt enable.
// R5: Reset keeps aux outputs and direction.
// R6: Power-on, host reset, software reset.
// R7: One byte per handshake, MSB first.
// R8: Byte output uses low lanes, upper zero.
// R9: Byte input captures low lanes only.
// R10: Word format and register 3 use sixteen lanes.
// R11: Selectable high-true or low-true data lines.
// R12: Register 3 write sets data, direction only.
// R13: Direction low for output, high for input.
// R14: Strobe clears on acknowledge ready-to-busy.
// R15: Register 3 read sets direction high, no handshake.
module phpr_port
    import phpr_pkg::*;
#(
    parameter bit DOUT_CLEAR_FITTED = 1'b1
) (
    input  wire logic        aclk,                    // Host clock.
    input  wire logic        aresetn,                 // Host reset, low.
    input  wire logic [7:0]  s_axi_awaddr,            // Write address.
    input  wire logic        s_axi_awvalid,           // Write addr valid.
    output logic             s_axi_awready,           // Write addr ready.
    input  wire logic [31:0] s_axi_wdata,             // Write data.
    input  wire logic [3:0]  s_axi_wstrb,             // Byte strobes.
    input  wire logic        s_axi_wvalid,            // Write data valid.
    output logic             s_axi_wready,            // Write data ready.
    output logic [1:0]       s_axi_bresp,             // Write response.
    output logic             s_axi_bvalid,            // Response valid.
    input  wire logic        s_axi_bready,            // Response ready.
    input  wire logic [7:0]  s_axi_araddr,            // Read address.
    input  wire logic        s_axi_arvalid,           // Read addr valid.
    output logic             s_axi_arready,           // Read addr ready.
    output logic [31:0]      s_axi_rdata,             // Read data.
    output logic [1:0]       s_axi_rresp,             // Read response.
    output logic             s_axi_rvalid,            // Read data valid.
    input  wire logic        s_axi_rready,            // Read ready.
    output logic [15:0]      data_out,                // Data out lanes.
    input  wire logic [15:0] data_in,                 // Data in lanes.
    output logic             transfer_request_strobe, // Request strobe.
    input  wire logic        peripheral_ack_flag,     // High means busy.
    output logic             io_direction,            // High for input.
    output logic             aux_control_out_a,       // Aux output a.
    output logic             aux_control_out_b,       // Aux output b.
    output logic             peripheral_reset_n,      // Peripheral reset.
    output logic             irq                      // Interrupt level.
);
    // Two-stage synchronisers for pins from the peripheral.
    logic        flag_s1_reg, flag_s2_reg, flag_s3_reg;
    logic [15:0] din_s1_reg, din_s2_reg;
    always_ff @(posedge aclk) begin
        flag_s1_reg <= peripheral_ack_flag;
        flag_s2_reg <= flag_s1_reg;
        flag_s3_reg <= flag_s2_reg;
        din_s1_reg  <= data_in;
        din_s2_reg  <= din_s1_reg;
    end
    wire logic ack_rise = flag_s2_reg & ~flag_s3_reg;

    // Register and port state.
    logic        ie_reg, ie_next, word_reg, word_next, lowt_reg, lowt_next;
    logic        auxa_reg, auxa_next, auxb_reg, auxb_next;
    logic        dir_reg, dir_next, strobe_reg, strobe_next;
    logic [15:0] dout_reg, dout_next, rx_reg, rx_next, pin_reg, pin_next;
    logic [15:0] txw_reg, txw_next;
    logic        hi_pend_reg, hi_pend_next, inmode_reg, inmode_next;
    logic        swrst_reg, swrst_next;
    logic [$clog2(PRESET_CYC+1)-1:0] rst_cnt_reg, rst_cnt_next;
    logic        prst_n_reg, prst_n_next;
    logic [IRQ_W-1:0] sts_reg, sts_next, mask_reg, mask_next;
    logic        irq_reg, irq_next;
    phpr_state_t st_reg, st_next;
    logic        awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
    logic [7:0]  awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0]  ws_reg, ws_next;
    logic        arr_reg, arr_next, rv_reg, rv_next;
    logic [31:0] rd_reg, rd_next;
    logic [1:0]  br_reg, br_next, rr_reg, rr_next;

    // Polarity is applied at the pins so internal values stay logical.
    function automatic logic [15:0] pol(input logic [15:0] v,
                                        input logic lt);
        pol = lt ? ~v : v; // R11
    endfunction

    wire logic [15:0] din_log = pol(din_s2_reg, lowt_reg);
    wire logic have_aw = awr_reg | s_axi_awvalid;
    wire logic have_w  = wr_reg | s_axi_wvalid;

    // Next-state logic for bus, registers and handshake.
    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        do_wr, do_rd, start;
        wa = awr_reg ? awa_reg : s_axi_awaddr;
        wd = wr_reg ? wd_reg : s_axi_wdata;
        ws = wr_reg ? ws_reg : s_axi_wstrb;
        do_wr = have_aw && have_w && !bv_reg;
        do_rd = s_axi_arvalid && arr_reg && !rv_reg;
        start = 1'b0;
        awr_next = awr_reg; awa_next = awa_reg;
        wr_next = wr_reg; wd_next = wd_reg; ws_next = ws_reg;
        bv_next = bv_reg; br_next = br_reg;
        arr_next = !rv_reg; rv_next = rv_reg; rd_next = rd_reg;
        rr_next = rr_reg;
        ie_next = ie_reg; word_next = word_reg; lowt_next = lowt_reg;
        auxa_next = auxa_reg; auxb_next = auxb_reg; dir_next = dir_reg;
        strobe_next = strobe_reg; dout_next = dout_reg; rx_next = rx_reg;
        txw_next = txw_reg; hi_pend_next = hi_pend_reg;
        inmode_next = inmode_reg; swrst_next = 1'b0;
        st_next = st_reg; sts_next = sts_reg; mask_next = mask_reg;
        rst_cnt_next = rst_cnt_reg;
        prst_n_next = (rst_cnt_reg == '0);
        if (rst_cnt_reg != '0) begin
            rst_cnt_next = rst_cnt_reg - 1'b1; // R1
        end
        // Address and data are latched separately; either may come first.
        if (s_axi_awvalid && !awr_reg && !do_wr) begin
            awr_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wr_reg && !do_wr) begin
            wr_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
        // Handshake: strobe rises two cycles after a transfer write sets up data, one cycle after the low byte.
        unique case (st_reg)
            PHPR_IDLE: begin
                if (hi_pend_reg) begin
                    st_next = PHPR_SETUP;
                end
            end
            PHPR_SETUP: begin
                strobe_next = 1'b1;
                st_next = PHPR_WAIT;
            end
            PHPR_WAIT: begin
                if (ack_rise) begin
                    strobe_next = 1'b0; // R14
                    if (inmode_reg) begin
                        rx_next = word_reg ? din_log
                                : {8'h00, din_log[7:0]}; // R9 R10
                        sts_next[IRQ_RXDONE] = 1'b1;
                    end
                    if (hi_pend_reg && !word_reg && !inmode_reg) begin
                        dout_next = {8'h00, txw_reg[7:0]}; // R7 R8
                        hi_pend_next = 1'b0;
                        st_next = PHPR_SETUP;
                    end else begin
                        hi_pend_next = 1'b0;
                        sts_next[IRQ_DONE] = 1'b1;
                        st_next = PHPR_IDLE;
                    end
                end
            end
            default: st_next = PHPR_IDLE;
        endcase
        if (do_wr) begin
            awr_next = 1'b0;
            wr_next = 1'b0;
            bv_next = 1'b1;
            br_next = AXI_OKAY;
            unique case (wa)
                ADDR_CTRL: if (ws[0]) begin
                    swrst_next = wd[CTRL_SWRST]; // R6
                    ie_next = wd[CTRL_IE];
                    word_next = wd[CTRL_WORD];
                    lowt_next = wd[CTRL_LOWTRUE];
                    auxa_next = wd[CTRL_AUXA];
                    auxb_next = wd[CTRL_AUXB];
                end
                ADDR_XFER: start = (st_reg == PHPR_IDLE) && !hi_pend_reg;
                ADDR_WORD: begin
                    dout_next = wd[15:0]; // R10 R12
                    dir_next = 1'b0;
                end
                ADDR_MASK: mask_next = wd[IRQ_W-1:0];
                ADDR_STATUS, ADDR_IRQ, ADDR_RXDATA: ;
                default: br_next = AXI_SLVERR;
            endcase
            if (start) begin
                inmode_next = wd[XFER_INPUT];
                dir_next = wd[XFER_INPUT]; // R13
                txw_next = wd[15:0];
                hi_pend_next = 1'b1;
                if (!wd[XFER_INPUT]) begin
                    dout_next = word_reg ? wd[15:0]
                              : {8'h00, wd[15:8]}; // R7 R8 R10 R13
                end
            end
        end
        if (do_rd) begin
            arr_next = 1'b0;
            rv_next = 1'b1;
            rr_next = AXI_OKAY;
            rd_next = '0;
            unique case (s_axi_araddr)
                ADDR_CTRL: rd_next = {26'h0, auxb_reg, auxa_reg,
                                      lowt_reg, word_reg, ie_reg, 1'b0};
                ADDR_XFER: rd_next = {15'h0, inmode_reg, txw_reg};
                ADDR_STATUS: rd_next = {27'h0, prst_n_reg, dir_reg,
                    flag_s2_reg, strobe_reg, st_reg != PHPR_IDLE};
                ADDR_WORD: begin
                    rd_next = {16'h0, din_log}; // R10 R15
                    dir_next = 1'b1; // R15
                end
                ADDR_IRQ: begin
                    rd_next = {30'h0, sts_reg};
                    sts_next = '0;
                end
                ADDR_MASK: rd_next = {30'h0, mask_reg};
                ADDR_RXDATA: rd_next = {16'h0, rx_reg};
                default: rr_next = AXI_SLVERR;
            endcase
            // A fresh event in the clearing cycle still sets its bit.
            if (st_reg == PHPR_WAIT && ack_rise && !(hi_pend_reg &&
                !word_reg && !inmode_reg)) begin
                sts_next[IRQ_DONE] = 1'b1;
                sts_next[IRQ_RXDONE] = inmode_reg;
            end
        end
        // Software reset repeats the bus reset for peripheral reset, handshake, interrupt enable and lanes only.
        if (swrst_reg) begin
            rst_cnt_next = ($bits(rst_cnt_reg))'(PRESET_CYC); // R1 R6
            prst_n_next = 1'b0;
            strobe_next = 1'b0; // R2
            st_next = PHPR_IDLE;
            hi_pend_next = 1'b0;
            ie_next = 1'b0; // R4
            if (DOUT_CLEAR_FITTED) begin
                dout_next = '0; // R3
            end
        end
        irq_next = ie_next && |(sts_next & mask_next);
        pin_next = pol(dout_next, lowt_next); // R11
    end

    // Register stage; aux and direction keep values on reset.
    always_ff @(posedge aclk) begin
        auxa_reg <= auxa_next; // R5
        auxb_reg <= auxb_next;
        dir_reg  <= dir_next;
        txw_reg  <= txw_next;
        rx_reg   <= rx_next;
        pin_reg  <= (!aresetn && DOUT_CLEAR_FITTED) ? '0 : pin_next; // R3
        if (!aresetn) begin
            rst_cnt_reg <= ($bits(rst_cnt_reg))'(PRESET_CYC); // R1 R6
            prst_n_reg  <= 1'b0;
            strobe_reg  <= 1'b0; // R2
            st_reg      <= PHPR_IDLE;
            ie_reg      <= 1'b0; // R4
            // Without the jumper the lanes keep their previous data; reset returns them to high-true polarity.
            dout_reg    <= DOUT_CLEAR_FITTED ? 16'h0000 : dout_next; // R3
            hi_pend_reg <= 1'b0;
            inmode_reg  <= 1'b0;
            word_reg    <= 1'b0;
            lowt_reg    <= 1'b0;
            swrst_reg   <= 1'b0;
            sts_reg     <= '0;
            mask_reg    <= '0;
            irq_reg     <= 1'b0;
            awr_reg <= 1'b0; wr_reg <= 1'b0;
            bv_reg <= 1'b0;
            arr_reg <= 1'b0; rv_reg <= 1'b0;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
            prst_n_reg  <= prst_n_next;
            strobe_reg  <= strobe_next;
            st_reg      <= st_next;
            ie_reg      <= ie_next;
            dout_reg    <= dout_next;
            hi_pend_reg <= hi_pend_next;
            inmode_reg  <= inmode_next;
            word_reg    <= word_next;
            lowt_reg    <= lowt_next;
            swrst_reg   <= swrst_next;
            sts_reg     <= sts_next;
            mask_reg    <= mask_next;
            irq_reg     <= irq_next;
            awr_reg <= awr_next; awa_reg <= awa_next; wr_reg <= wr_next;
            wd_reg <= wd_next; ws_reg <= ws_next; bv_reg <= bv_next;
            br_reg <= br_next; arr_reg <= arr_next; rv_reg <= rv_next;
            rd_reg <= rd_next; rr_reg <= rr_next;
        end
    end

    // Pin and bus outputs, all straight from flip-flops.
    assign data_out                = pin_reg;
    assign transfer_request_strobe = strobe_reg;
    assign io_direction            = dir_reg;
    assign aux_control_out_a       = auxa_reg;
    assign aux_control_out_b       = auxb_reg;
    assign peripheral_reset_n      = prst_n_reg;
    assign irq                     = irq_reg;
    assign s_axi_awready           = ~awr_reg;
    assign s_axi_wready            = ~wr_reg;
    assign s_axi_bvalid            = bv_reg;
    assign s_axi_bresp             = br_reg;
    assign s_axi_arready           = arr_reg;
    assign s_axi_rvalid            = rv_reg;
    assign s_axi_rdata             = rd_reg;
    assign s_axi_rresp             = rr_reg;
endmodule

// ### phpr_pkg.sv
// Register map, field positions and timing of the port.
package phpr_pkg;
    // Register byte addresses; index 3 is the direct word.
    localparam int unsigned WORD_DIRECT_IDX = 3;
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_XFER   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_WORD   = 8'(WORD_DIRECT_IDX * 4);
    localparam logic [7:0] ADDR_IRQ    = 8'h10;
    localparam logic [7:0] ADDR_MASK   = 8'h14;
    localparam logic [7:0] ADDR_RXDATA = 8'h18;
    // Control register fields.
    localparam int unsigned CTRL_SWRST   = 0;
    localparam int unsigned CTRL_IE      = 1;
    localparam int unsigned CTRL_WORD    = 2;
    localparam int unsigned CTRL_LOWTRUE = 3;
    localparam int unsigned CTRL_AUXA    = 4;
    localparam int unsigned CTRL_AUXB    = 5;
    // Transfer register: bit 16 selects input.
    localparam int unsigned XFER_INPUT   = 16;
    // Interrupt status bits.
    localparam int unsigned IRQ_DONE     = 0;
    localparam int unsigned IRQ_RXDONE   = 1;
    localparam int unsigned IRQ_W        = 2;
    // Timing.
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned PRESET_US    = 15;
    localparam int unsigned PRESET_CYC   =
        (PRESET_US * (CLK_HZ / 1_000_000) > 0) ?
        PRESET_US * (CLK_HZ / 1_000_000) : 1;
    localparam logic [1:0] AXI_OKAY      = 2'b00;
    localparam logic [1:0] AXI_SLVERR    = 2'b10;
    // Handshake states.
    typedef enum logic [1:0] {
        PHPR_IDLE  = 2'b00,
        PHPR_SETUP = 2'b01,
        PHPR_WAIT  = 2'b10
    } phpr_state_t;
endpackage

// ### phpr_port_props.sv
// Concurrent checks on the port's pins and bus.
`timescale 1ns/1ps
module phpr_port_props
    import phpr_pkg::*;
(
    input wire logic        aclk,          // Clock.
    input wire logic        aresetn,       // Reset, low.
    input wire logic [7:0]  s_axi_awaddr,  // Write address.
    input wire logic        s_axi_awvalid, // Aw valid.
    input wire logic        s_axi_awready, // Aw ready.
    input wire logic [7:0]  s_axi_araddr,  // Read address.
    input wire logic        s_axi_arvalid, // Ar valid.
    input wire logic        s_axi_arready, // Ar ready.
    input wire logic [15:0] data_out,      // Data lanes.
    input wire logic        transfer_request_strobe, // Strobe.
    input wire logic        peripheral_ack_flag,     // Busy flag.
    input wire logic        io_direction,            // Direction.
    input wire logic        aux_control_out_a,       // Aux output a.
    input wire logic        peripheral_reset_n,      // Peripheral reset.
    input wire logic        irq                      // Interrupt.
);
    logic [15:0] low_cnt = 16'h0;
    logic        armed   = 1'b0;
    logic        aux_q;
    logic        dir_q;

    // Reset low time; kept outputs copied outside reset.
    always_ff @(posedge aclk) begin
        if (!aresetn || !peripheral_reset_n)
            low_cnt <= (&low_cnt) ? low_cnt : low_cnt + 16'h1;
        else
            low_cnt <= 16'h0;
        armed <= armed | aresetn;
        if (aresetn) begin
            aux_q <= aux_control_out_a;
            dir_q <= io_direction;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_clears: assert property ($rose(aresetn) |->
        !transfer_request_strobe && !peripheral_reset_n)
        else $error("reset state wrong");
    a_preset_width: assert property ($rose(peripheral_reset_n) |->
        low_cnt >= 16'(PRESET_CYC)) else $error("peripheral reset short");
    a_preset_ends: assert property ($rose(aresetn) |->
        ##[100:200] peripheral_reset_n) else $error("peripheral reset stuck");
    a_irq_quiet: assert property ($rose(aresetn) |-> !irq [*3])
        else $error("interrupt after reset");
    a_kept_outputs: assert property (armed && $rose(aresetn) |->
        aux_control_out_a == aux_q && io_direction == dir_q)
        else $error("kept output changed");
    a_ack_clears: assert property (transfer_request_strobe &&
        $rose(peripheral_ack_flag) |-> ##[1:4] !transfer_request_strobe)
        else $error("strobe not cleared");
    a_data_first: assert property ($rose(transfer_request_strobe) |->
        $stable(data_out) && $stable(io_direction))
        else $error("lanes not set up");
    a_data_held: assert property (transfer_request_strobe &&
        $past(transfer_request_strobe) |-> $stable(data_out))
        else $error("lanes moved");
    a_word_no_hs: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_awaddr == ADDR_WORD && !transfer_request_strobe |=>
        !transfer_request_strobe [*6]) else $error("direct write strobed");
    a_word_rd_dir: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == ADDR_WORD |-> ##[1:3] io_direction)
        else $error("direction low");

    c_strobe: cover property ($rose(transfer_request_strobe));
    c_irq: cover property ($rose(irq));
    c_preset: cover property ($rose(peripheral_reset_n));
endmodule

bind phpr_port phpr_port_props phpr_port_props_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .data_out, .transfer_request_strobe,
    .peripheral_ack_flag, .io_direction, .aux_control_out_a,
    .peripheral_reset_n, .irq);

// ### phpr_periph_model.sv
// Peripheral model at the far side of the handshake.
`timescale 1ns/1ps
module phpr_periph_model (
    input  wire logic        aclk,       // Host clock.
    input  wire logic        strobe,     // Request strobe.
    input  wire logic [15:0] data_out,   // Lanes from the port.
    input  wire logic [3:0]  ack_delay,  // Delay to Busy.
    input  wire logic [15:0] rx_word,    // Input word offered.
    input  wire logic        hold_lanes, // Hold idle lanes.
    output logic             ack_flag,   // High means Busy.
    output logic [15:0]      data_in,    // Lanes toward the port.
    output logic [15:0]      seen_word,  // Lanes at Busy.
    output logic [7:0]       seen_cnt    // Handshakes answered.
);
    logic [3:0] wait_cnt;

    initial begin
        ack_flag = 1'b0;
        data_in  = 16'h0;
        seen_cnt = 8'h0;
        wait_cnt = 4'h0;
    end

    // Idle lanes toggle each cycle unless hold_lanes holds them at rx_word, so stale data never passes as valid.
    always @(negedge aclk) begin
        if (ack_flag) begin
            if (!strobe)
                ack_flag <= 1'b0;
        end else if (strobe) begin
            data_in  <= rx_word;
            wait_cnt <= wait_cnt + 4'h1;
            if (wait_cnt >= ack_delay) begin
                ack_flag  <= 1'b1;
                seen_word <= data_out;
                seen_cnt  <= seen_cnt + 8'h1;
                wait_cnt  <= 4'h0;
            end
        end else begin
            data_in <= hold_lanes ? rx_word : ~data_in;
        end
    end
endmodule

// ### phpr_port_tb.sv
// Testbench for the port with a peripheral model.
`timescale 1ns/1ps
module phpr_port_tb
    import phpr_pkg::*;
;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, hold_lanes, irq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, transfer_request_strobe, peripheral_ack_flag;
    logic        io_direction, aux_control_out_a, aux_control_out_b;
    logic        peripheral_reset_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, seen_cnt;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, ack_delay;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] data_out, data_in, seen_word, rx_word;
    int          n_errors = 0, total_checks = 0, waited, n;

    phpr_port #(.DOUT_CLEAR_FITTED(1'b1)) phpr_port_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .data_out, .data_in, .transfer_request_strobe,
        .peripheral_ack_flag, .io_direction, .aux_control_out_a,
        .aux_control_out_b, .peripheral_reset_n, .irq);
    phpr_periph_model phpr_periph_model_inst (.aclk, .data_out, .ack_delay,
        .strobe(transfer_request_strobe), .rx_word, .hold_lanes, .data_in,
        .ack_flag(peripheral_ack_flag), .seen_word, .seen_cnt);

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Comparison, verdict and give-up helpers.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic give_up;
        n_errors++;
        report_and_stop();
    endtask
    task automatic pause(input int c);
        repeat (c) @(posedge aclk);
        #1;
    endtask
    task automatic wait_hi(ref logic s);
        for (waited = 0; waited < 400 && s !== 1'b1; waited++)
            @(posedge aclk);
        if (waited == 400) give_up();
    endtask
    task automatic wait_acks(input int c);
        for (waited = 0; waited < 400 && seen_cnt !== 8'(c); waited++)
            @(posedge aclk);
        if (waited == 400) give_up();
    endtask

    // Bus cycles: each channel is released on the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        logic [2:0] r;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (k = 0; k < 200; k++) begin
            #1 r = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge aclk);
            if (r[2]) s_axi_awvalid <= 1'b0;
            if (r[1]) s_axi_wvalid <= 1'b0;
            if (r[0]) break;
        end
        if (k == 200) give_up();
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        int k;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (k = 0; k < 200; k++) begin
            #1 r = {s_axi_arready, s_axi_rvalid};
            @(posedge aclk);
            if (r[1]) s_axi_arvalid <= 1'b0;
            if (r[0]) break;
        end
        if (k == 200) give_up();
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Power-on state and peripheral reset width.
    task automatic t_power_on;
        check(transfer_request_strobe, 1'b0);
        check(data_out, 16'h0);
        check(irq, 1'b0);
        wait_hi(peripheral_reset_n);
        check(waited >= PRESET_CYC - 4, 1'b1);
        $display("power-on test done");
    endtask

    // Direct word access, polarity and a bad address.
    task automatic t_direct;
        wr(ADDR_WORD, 32'h8001);
        hold_lanes <= 1'b1;
        rx_word    <= 16'ha5c3;
        pause(1);
        check(data_out, 16'h8001);
        check({io_direction, transfer_request_strobe}, 2'b00);
        rdr(ADDR_WORD);
        pause(1);
        check({rd[15:0], io_direction}, {16'ha5c3, 1'b1});
        wr(ADDR_CTRL, 32'h08);
        pause(1);
        check(data_out, 16'h7ffe);
        wr(8'h1c, 32'h1);
        check(rs, AXI_SLVERR);
        wr(ADDR_CTRL, 32'h02);
        $display("direct word test done");
    endtask

    // Byte output: high byte first, low lanes only.
    task automatic t_byte_out;
        wr(ADDR_MASK, 32'h1);
        ack_delay <= 4'h6;
        n = seen_cnt;
        wr(ADDR_XFER, 32'h12ab);
        pause(1);
        check({io_direction, data_out}, {1'b0, 16'h0012});
        wait_acks(n + 1);
        check(seen_word, 16'h0012);
        wait_acks(n + 2);
        check(seen_word, 16'h00ab);
        wait_hi(irq);
        rdr(ADDR_IRQ);
        pause(2);
        check({rd[0], irq}, 2'b10);
        check(seen_cnt, 8'(n + 2));
        $display("byte output test done");
    endtask

    // Word output with interrupt masked, then unmasked.
    task automatic t_word_out;
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_CTRL, 32'h06);
        ack_delay <= 4'h1;
        n = seen_cnt;
        wr(ADDR_XFER, 32'hbeef);
        wait_acks(n + 1);
        check(seen_word, 16'hbeef);
        pause(20);
        check({seen_cnt, irq}, {8'(n + 1), 1'b0});
        wr(ADDR_MASK, 32'h1);
        wait_hi(irq);
        rdr(ADDR_IRQ);
        $display("word output test done");
    endtask

    // Byte then word input.
    task automatic t_in;
        wr(ADDR_MASK, 32'h2);
        wr(ADDR_CTRL, 32'h02);
        hold_lanes <= 1'b0;
        rx_word    <= 16'h7f41;
        ack_delay  <= 4'h2;
        wr(ADDR_XFER, 32'h10000);
        pause(1);
        check(io_direction, 1'b1);
        wait_hi(irq);
        rdr(ADDR_IRQ);
        check(rd[1], 1'b1);
        rdr(ADDR_RXDATA);
        check(rd[15:0], 16'h0041);
        wr(ADDR_CTRL, 32'h06);
        wr(ADDR_XFER, 32'h10000);
        wait_hi(irq);
        rdr(ADDR_IRQ);
        rdr(ADDR_RXDATA);
        check(rd[15:0], 16'h7f41);
        $display("input test done");
    endtask

    // Software and host resets keep aux and direction.
    task automatic t_resets;
        wr(ADDR_CTRL, 32'h32);
        wr(ADDR_WORD, 32'h3c3c);
        wr(ADDR_CTRL, 32'h33);
        pause(1);
        check({data_out, peripheral_reset_n}, 17'h0);
        check({aux_control_out_a, aux_control_out_b, io_direction}, 3'b110);
        rdr(ADDR_CTRL);
        check(rd[1], 1'b0);
        wait_hi(peripheral_reset_n);
        wr(ADDR_WORD, 32'h5a5a);
        rdr(ADDR_WORD);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        check({aux_control_out_a, aux_control_out_b, io_direction}, 3'b111);
        check(data_out, 16'h0);
        wait_hi(peripheral_reset_n);
        $display("reset test done");
    endtask

    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, hold_lanes} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        ack_delay = 4'h1;
        rx_word = 16'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        t_power_on();
        t_direct();
        t_byte_out();
        t_word_out();
        t_in();
        t_resets();
        report_and_stop();
    end
endmodule
